// File: logic/pss_top.v
`timescale 1ns/1ps
`include "pss_consts.vh"
module pss_top #(
  parameter ADDR_W = `PSS_ADDR_W,
  parameter LANES = `PSS_LANES,
  parameter FIFO_DEPTH = `PSS_FIFO_DEPTH,
  parameter FIFO_PTR_W = `PSS_FIFO_PTR_W
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_clk_en,
  input wire i_clock_qualify_n,
  input wire i_chip_select_1_n,
  input wire i_chip_select_2,
  input wire i_chip_select_3_n,
  input wire i_burst_step_or_load,
  input wire i_write_strobe_n,
  input wire [LANES-1:0] i_byte_lane_write_n,
  input wire [ADDR_W-1:0] i_addr,
  input wire i_burst_order,
  input wire i_output_drive_n,
  input wire i_sleep_request,
  input wire [LANES*8-1:0] i_data_io,
  output wire [LANES*8-1:0] o_data_io,
  output wire o_data_io_oe,
  input wire [LANES-1:0] i_lane_parity_io,
  output wire [LANES-1:0] o_lane_parity_io,
  output wire o_lane_parity_io_oe,
  output wire o_sleeping
);

  // ********************************
  // local constants
  // ********************************
  localparam LANE_W = `PSS_LANE_W;
  localparam LANE_D = `PSS_LANE_DATA_W;
  localparam WORD_W = LANES * LANE_W;
  localparam ENTRY_W = ADDR_W + LANES + WORD_W;
  localparam [1:0] SLP_AWAKE = 2'h0;
  localparam [1:0] SLP_ENTER = 2'h1;
  localparam [1:0] SLP_ASLEEP = 2'h2;
  localparam [1:0] SLP_EXIT = 2'h3;
  localparam [`PSS_SLEEP_CNT_W-1:0] ENTER_LAST = `PSS_SLEEP_ENTER_CYC - 2'h1;
  localparam [`PSS_SLEEP_CNT_W-1:0] EXIT_LAST = `PSS_SLEEP_EXIT_CYC - 2'h1;
  localparam [LANES-1:0] NONE_N = {LANES{1'b1}};

  // ********************************
  // functions
  // ********************************
  // low two address bits of a given burst beat
  function [`PSS_BURST_W-1:0] beat_bits;
    input order;
    input [`PSS_BURST_W-1:0] start;
    input [`PSS_BURST_W-1:0] beat;
    begin
      if (order == `PSS_ORDER_INTERLEAVED) begin
        beat_bits = start ^ beat;
      end else begin
        beat_bits = start + beat;
      end
    end
  endfunction

  // overlay newer lanes onto an older word
  function [WORD_W-1:0] merge;
    input [WORD_W-1:0] old_word;
    input [WORD_W-1:0] new_word;
    input [LANES-1:0] lanes_n;
    integer k;
    begin
      merge = old_word;
      for (k = 0; k < LANES; k = k + 1) begin
        if (!lanes_n[k]) begin
          merge[k*LANE_W +: LANE_W] = new_word[k*LANE_W +: LANE_W];
        end
      end
    end
  endfunction

  // ********************************
  // declarations
  // ********************************
  reg [1:0] slp_state_reg;
  reg [1:0] slp_state_next;
  reg [`PSS_SLEEP_CNT_W-1:0] slp_cnt_reg;
  reg [`PSS_SLEEP_CNT_W-1:0] slp_cnt_next;
  reg strap_taken_reg;
  reg order_reg;
  reg burst_active_reg;
  reg burst_write_reg;
  reg [ADDR_W-1:0] burst_base_reg;
  reg [`PSS_BURST_W-1:0] burst_cnt_reg;
  reg s1_valid_reg;
  reg s1_write_reg;
  reg [ADDR_W-1:0] s1_addr_reg;
  reg [LANES-1:0] s1_lanes_n_reg;
  reg s2_valid_reg;
  reg [ADDR_W-1:0] s2_addr_reg;
  reg [LANES-1:0] s2_lanes_n_reg;
  reg out_valid_reg;
  reg [WORD_W-1:0] out_word_reg;
  reg [WORD_W-1:0] rd_merged;
  wire cs_all;
  wire qualified;
  wire awake;
  wire flush;
  wire adv;
  wire cmd_start;
  wire cmd_step;
  wire [`PSS_BURST_W-1:0] next_beat;
  wire [ADDR_W-1:0] step_addr;
  wire [WORD_W-1:0] in_word;
  wire [WORD_W-1:0] mem_rd_word;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [ENTRY_W-1:0] fifo_in_data;
  wire [ENTRY_W-1:0] fifo_out_data;
  wire [ADDR_W-1:0] head_addr;
  wire [LANES-1:0] head_lanes_n;
  wire [WORD_W-1:0] head_word;
  wire head_hit;
  wire late_hit;

  // ********************************
  // pin packing
  // ********************************
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_pack
      assign in_word[g*LANE_W +: LANE_W] =
        {i_lane_parity_io[g], i_data_io[g*LANE_D +: LANE_D]};
      assign o_data_io[g*LANE_D +: LANE_D] =
        out_word_reg[g*LANE_W +: LANE_D];
      assign o_lane_parity_io[g] = out_word_reg[g*LANE_W + LANE_D];
    end
  endgenerate

  // ********************************
  // command decode
  // ********************************
  assign cs_all = !i_chip_select_1_n && i_chip_select_2 &&
                  !i_chip_select_3_n;
  assign qualified = i_clk_en && !i_clock_qualify_n;
  assign awake = (slp_state_reg == SLP_AWAKE) ||
                 (slp_state_reg == SLP_ENTER);
  // full buffer stalls the pipeline like a qualify stall
  assign adv = qualified && fifo_in_ready && awake;
  assign flush = i_clk_en && (slp_state_reg == SLP_ENTER) &&
                 (slp_state_next == SLP_ASLEEP);
  assign cmd_start = !i_burst_step_or_load && cs_all;
  assign cmd_step = i_burst_step_or_load && burst_active_reg;
  assign next_beat = burst_cnt_reg + 1'b1;
  assign step_addr = {burst_base_reg[ADDR_W-1:`PSS_BURST_W],
    beat_bits(order_reg, burst_base_reg[`PSS_BURST_W-1:0], next_beat)};

  // ********************************
  // burst order strap
  // ********************************
  // caught once after reset release; the strap is not meant to move
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      strap_taken_reg <= 1'b0;
      order_reg <= `PSS_ORDER_LINEAR;
    end else if (i_clk_en && !strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      order_reg <= i_burst_order;
    end
  end

  // ********************************
  // burst and command stage
  // ********************************
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      burst_active_reg <= 1'b0;
      burst_write_reg <= 1'b0;
      burst_base_reg <= {ADDR_W{1'b0}};
      burst_cnt_reg <= `PSS_BURST_RESET;
      s1_valid_reg <= 1'b0;
      s1_write_reg <= 1'b0;
      s1_addr_reg <= {ADDR_W{1'b0}};
      s1_lanes_n_reg <= NONE_N;
    end else if (flush) begin
      burst_active_reg <= 1'b0;
      s1_valid_reg <= 1'b0;
    end else if (adv) begin
      if (cmd_start) begin
        burst_active_reg <= 1'b1;
        burst_write_reg <= !i_write_strobe_n;
        burst_base_reg <= i_addr;
        burst_cnt_reg <= `PSS_BURST_RESET;
        s1_valid_reg <= 1'b1;
        s1_write_reg <= !i_write_strobe_n;
        s1_addr_reg <= i_addr;
        s1_lanes_n_reg <= i_byte_lane_write_n;
      end else if (cmd_step) begin
        burst_cnt_reg <= next_beat;
        s1_valid_reg <= 1'b1;
        s1_write_reg <= burst_write_reg;
        s1_addr_reg <= step_addr;
        s1_lanes_n_reg <= i_byte_lane_write_n;
      end else begin
        if (!i_burst_step_or_load) begin
          burst_active_reg <= 1'b0;
        end
        s1_valid_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // read merge
  // ********************************
  // queued or arriving writes are newer than the array contents
  assign head_addr = fifo_out_data[ENTRY_W-1 -: ADDR_W];
  assign head_lanes_n = fifo_out_data[WORD_W +: LANES];
  assign head_word = fifo_out_data[WORD_W-1:0];
  assign head_hit = fifo_out_valid && (head_addr == s1_addr_reg);
  assign late_hit = s2_valid_reg && (s2_addr_reg == s1_addr_reg);

  always @* begin
    rd_merged = mem_rd_word;
    if (head_hit) begin
      rd_merged = merge(rd_merged, head_word, head_lanes_n);
    end
    if (late_hit) begin
      rd_merged = merge(rd_merged, in_word, s2_lanes_n_reg);
    end
  end

  // ********************************
  // data stage
  // ********************************
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      s2_valid_reg <= 1'b0;
      s2_addr_reg <= {ADDR_W{1'b0}};
      s2_lanes_n_reg <= NONE_N;
      out_valid_reg <= 1'b0;
      out_word_reg <= {WORD_W{1'b0}};
    end else if (flush) begin
      s2_valid_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else if (adv) begin
      out_valid_reg <= s1_valid_reg && !s1_write_reg;
      if (s1_valid_reg && !s1_write_reg) begin
        out_word_reg <= rd_merged;
      end
      s2_valid_reg <= s1_valid_reg && s1_write_reg &&
                      (s1_lanes_n_reg != NONE_N);
      s2_addr_reg <= s1_addr_reg;
      s2_lanes_n_reg <= s1_lanes_n_reg;
    end
  end

  assign fifo_in_valid = adv && s2_valid_reg;
  assign fifo_in_data = {s2_addr_reg, s2_lanes_n_reg, in_word};
  // drain pauses while asleep, as do pushes, so the buffer never holds more than one entry
  assign fifo_out_ready = awake;

  // ********************************
  // output drive
  // ********************************
  // asynchronous drive enable
  assign o_data_io_oe = out_valid_reg && !i_output_drive_n && awake;
  assign o_lane_parity_io_oe = o_data_io_oe;

  // ********************************
  // sleep sequencing
  // ********************************
  always @* begin
    slp_state_next = slp_state_reg;
    slp_cnt_next = slp_cnt_reg;
    case (slp_state_reg)
      SLP_AWAKE: begin
        if (i_sleep_request) begin
          slp_state_next = SLP_ENTER;
          slp_cnt_next = 2'h1;
        end
      end
      SLP_ENTER: begin
        if (!i_sleep_request) begin
          slp_state_next = SLP_AWAKE;
        end else if (slp_cnt_reg == ENTER_LAST) begin
          slp_state_next = SLP_ASLEEP;
        end else begin
          slp_cnt_next = slp_cnt_reg + 1'b1;
        end
      end
      SLP_ASLEEP: begin
        if (!i_sleep_request) begin
          slp_state_next = SLP_EXIT;
          slp_cnt_next = 2'h1;
        end
      end
      SLP_EXIT: begin
        if (i_sleep_request) begin
          slp_state_next = SLP_ASLEEP;
        end else if (slp_cnt_reg == EXIT_LAST) begin
          slp_state_next = SLP_AWAKE;
        end else begin
          slp_cnt_next = slp_cnt_reg + 1'b1;
        end
      end
      default: begin
        slp_state_next = SLP_AWAKE;
        slp_cnt_next = 2'h0;
      end
    endcase
  end

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      slp_state_reg <= SLP_AWAKE;
      slp_cnt_reg <= 2'h0;
    end else if (i_clk_en) begin
      slp_state_reg <= slp_state_next;
      slp_cnt_reg <= slp_cnt_next;
    end
  end

  assign o_sleeping = !awake;

  // ********************************
  // write buffer and storage
  // ********************************
  // buffer follows the qualify stall so the pipeline freezes as one
  pss_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_clk_en(qualified),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  pss_mem #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_clk_en(qualified),
    .i_we(fifo_out_valid && fifo_out_ready),
    .i_waddr(head_addr),
    .i_lanes_n(head_lanes_n),
    .i_wdata(head_word),
    .i_raddr(s1_addr_reg),
    .o_rdata(mem_rd_word)
  );

endmodule // pss_top

// File: inc/pss_consts.vh
// Contract
// - clock qualified, all selects active, strobe high, load low: read starts, address taken
// - read data leaves the output register one edge later, driven only when enabled
// - any new command is accepted on the edge right after a read
// - a deselect tri-states the data pins after the following edge
// - burst counter gives up to four beats from one loaded address; here further steps wrap back to the loaded address
// - strap low picks linear order, high interleaved; only two low bits wrap
// - linear order counts the two low bits upward modulo four
// - interleaved order is start low bits XOR the beat count
// - step input high advances the burst regardless of selects and strobe
// - read or write type is caught at burst start and kept each beat
// - qualified, all selects active, strobe low: write starts, address and lanes taken
// - edge after a write command tri-states data pins whatever the drive enable
// - write data is latched on the second edge after the command
// - only selected byte lanes with their parity bits are written
// - sleep entry and exit each take two cycles; stored data survives
// - accesses pending at sleep entry are invalid and may not finish
// - qualify high makes the edge ignored; all state holds (sleep sequencer, sleep-entry flush and strap capture still run on i_clk_en)
// - after power-up the device is deselected with data pins tri-stated
// - drive enable acts without the clock and is masked during writes
// - sleep request is active high; held low the device runs normally
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// ********************************
// geometry
// ********************************
`define PSS_ADDR_W 17
`define PSS_LANES 4
`define PSS_LANE_W 9
`define PSS_LANE_DATA_W 8
`define PSS_BURST_W 2

// ********************************
// data buffer
// ********************************
`define PSS_FIFO_DEPTH 4
`define PSS_FIFO_PTR_W 2

// ********************************
// strap and reset values
// ********************************
`define PSS_ORDER_LINEAR 1'h0
`define PSS_ORDER_INTERLEAVED 1'h1
`define PSS_BURST_RESET 2'h0
`define PSS_LANES_NONE_N 4'hf

// ********************************
// sleep timing, in clock cycles
// ********************************
`define PSS_SLEEP_ENTER_CYC 2'h2
`define PSS_SLEEP_EXIT_CYC 2'h2
`define PSS_SLEEP_CNT_W 2

`endif

// File: logic/pss_mem.v
`timescale 1ns/1ps
module pss_mem #(
  parameter ADDR_W = 17,
  parameter LANES = 4,
  parameter LANE_W = 9
) (
  input wire i_clk_sys,
  input wire i_clk_en,
  input wire i_we,
  input wire [ADDR_W-1:0] i_waddr,
  input wire [LANES-1:0] i_lanes_n,
  input wire [LANES*LANE_W-1:0] i_wdata,
  input wire [ADDR_W-1:0] i_raddr,
  output wire [LANES*LANE_W-1:0] o_rdata
);

  localparam WORDS = 1 << ADDR_W;

  // ********************************
  // one array per lane
  // ********************************
  // separate arrays keep each lane to a single writing process
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      reg [LANE_W-1:0] lane_mem [0:WORDS-1];
      always @(posedge i_clk_sys) begin
        if (i_clk_en && i_we && !i_lanes_n[g]) begin
          lane_mem[i_waddr] <= i_wdata[g*LANE_W +: LANE_W];
        end
      end
      assign o_rdata[g*LANE_W +: LANE_W] = lane_mem[i_raddr];
    end
  endgenerate

endmodule // pss_mem

// File: logic/pss_fifo.v
`timescale 1ns/1ps
module pss_fifo #(
  parameter WIDTH = 57,
  parameter DEPTH = 4,
  parameter PTR_W = 2
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_clk_en,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  // depth must equal 2**PTR_W; full is the count's top bit
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0] count_reg;
  wire push;
  wire pop;

  assign o_in_ready = !count_reg[PTR_W];
  assign o_out_valid = (count_reg != {(PTR_W+1){1'b0}});
  assign o_out_data = store[rd_ptr_reg];
  assign push = i_clk_en && i_in_valid && o_in_ready;
  assign pop = i_clk_en && o_out_valid && i_out_ready;

  always @(posedge i_clk_sys) begin
    if (push) begin
      store[wr_ptr_reg] <= i_in_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // pss_fifo

// File: test/pss_ctl_model.sv
`timescale 1ns/1ps
// ************************
// controller data side
// ************************
module pss_ctl_model (
  input wire i_clk_sys,
  input wire i_put,
  input wire [35:0] i_word,
  input wire i_dev_oe,
  output wire [31:0] o_data,
  output wire [3:0] o_parity,
  output reg o_clash = 1'b0
);
  reg [35:0] last_reg = 36'h0_0000_0000;
  // word held over data edge
  // no pull on the bus: a released bus shows the inverse of the last word
  assign {o_parity, o_data} = i_put ? i_word : ~last_reg;
  always @(posedge i_clk_sys) begin
    if (i_put) begin
      last_reg <= i_word;
    end
    if (i_put && i_dev_oe) begin
      o_clash <= 1'b1;
    end
  end
endmodule // pss_ctl_model

// File: test/pss_chk.sv
`timescale 1ns/1ps
// ************************
// port checker
// ************************
module pss_chk #(
  parameter ADDR_W = 17,
  parameter LANES = 4
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_clk_en,
  input wire i_clock_qualify_n,
  input wire i_chip_select_1_n,
  input wire i_chip_select_2,
  input wire i_chip_select_3_n,
  input wire i_burst_step_or_load,
  input wire i_write_strobe_n,
  input wire [LANES-1:0] i_byte_lane_write_n,
  input wire [ADDR_W-1:0] i_addr,
  input wire i_burst_order,
  input wire i_output_drive_n,
  input wire i_sleep_request,
  input wire [LANES*8-1:0] i_data_io,
  input wire [LANES*8-1:0] o_data_io,
  input wire o_data_io_oe,
  input wire [LANES-1:0] i_lane_parity_io,
  input wire [LANES-1:0] o_lane_parity_io,
  input wire o_lane_parity_io_oe,
  input wire o_sleeping
);
  reg act_reg;
  reg wtype_reg;
  wire sel = !i_chip_select_1_n && i_chip_select_2 && !i_chip_select_3_n;
  // sleep request edges left out: entry may clear the pipeline
  wire go = i_clk_en && !i_clock_qualify_n && !o_sleeping && !i_sleep_request;
  wire stall = i_clk_en && i_clock_qualify_n && !o_sleeping && !i_sleep_request;
  wire rd = go && sel && !i_burst_step_or_load && i_write_strobe_n;
  wire wr = go && sel && !i_burst_step_or_load && !i_write_strobe_n;
  wire dsl = go && !sel && !i_burst_step_or_load;
  wire beat = go && i_burst_step_or_load && act_reg;
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      act_reg <= 1'b0;
      wtype_reg <= 1'b0;
    end else if (go && !i_burst_step_or_load) begin
      act_reg <= sel;
      wtype_reg <= !i_write_strobe_n;
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  sequence s_rd_go; rd ##1 go; endsequence
  sequence s_wr_go; wr ##1 go; endsequence
  sequence s_ds_go; dsl ##1 go; endsequence
  sequence s_zz_in; (i_clk_en && i_sleep_request) [*2]; endsequence
  property p_read_drive; s_rd_go |=> o_data_io_oe == !i_output_drive_n; endproperty
  a_read_drive: assert property (p_read_drive) else $error("read late");
  property p_write_quiet; s_wr_go |=> !o_data_io_oe; endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("wr drive");
  property p_desel; s_ds_go |=> !o_data_io_oe; endproperty
  a_desel: assert property (p_desel) else $error("desel drive");
  property p_wbeat; (beat && wtype_reg) ##1 go |=> !o_data_io_oe; endproperty
  a_wbeat: assert property (p_wbeat) else $error("wr beat drive");
  property p_rbeat; (beat && !wtype_reg && !i_write_strobe_n && !sel) ##1 go
    |=> o_data_io_oe == !i_output_drive_n; endproperty
  a_rbeat: assert property (p_rbeat) else $error("rd beat lost");
  property p_stall; stall |=> $stable(o_data_io) && $stable(o_lane_parity_io);
  endproperty
  a_stall: assert property (p_stall) else $error("stall moved");
  property p_oe_gate; o_lane_parity_io_oe == o_data_io_oe
    && (!o_data_io_oe || !i_output_drive_n); endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("oe gate");
  property p_sleep_in; !o_sleeping ##0 s_zz_in |=> o_sleeping; endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no sleep");
  property p_sleep_dark; o_sleeping |-> !o_data_io_oe; endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("sleep oe");
  property p_power_up; disable iff (1'b0) i_reset |-> !o_data_io_oe; endproperty
  a_power_up: assert property (p_power_up) else $error("reset oe");
endmodule // pss_chk

bind pss_top pss_chk #(.ADDR_W(ADDR_W), .LANES(LANES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_clk_en(i_clk_en),
  .i_clock_qualify_n(i_clock_qualify_n),
  .i_chip_select_1_n(i_chip_select_1_n), .i_chip_select_2(i_chip_select_2),
  .i_chip_select_3_n(i_chip_select_3_n),
  .i_burst_step_or_load(i_burst_step_or_load),
  .i_write_strobe_n(i_write_strobe_n),
  .i_byte_lane_write_n(i_byte_lane_write_n), .i_addr(i_addr),
  .i_burst_order(i_burst_order), .i_output_drive_n(i_output_drive_n),
  .i_sleep_request(i_sleep_request), .i_data_io(i_data_io),
  .o_data_io(o_data_io), .o_data_io_oe(o_data_io_oe),
  .i_lane_parity_io(i_lane_parity_io), .o_lane_parity_io(o_lane_parity_io),
  .o_lane_parity_io_oe(o_lane_parity_io_oe), .o_sleeping(o_sleeping));

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic qn = 1'b0;
  logic order = 1'b0;
  logic drn = 1'b0;
  logic slp = 1'b0;
  logic put = 1'b0;
  logic [2:0] cmd = 3'h1;
  logic [3:0] ln = 4'hf;
  logic [5:0] ad = 6'h00;
  logic [35:0] pw = 36'h0_0000_0000;
  logic [35:0] ex [0:63];
  wire [31:0] dq_in;
  wire [31:0] dq_out;
  wire [3:0] pq_in;
  wire [3:0] pq_out;
  wire oe;
  wire poe;
  wire sleeping;
  wire clash;
  wire [35:0] rdw = {pq_out, dq_out};
  int failures = 0;
  int total_checks = 0;
  always #10 clk_sys = ~clk_sys;
  // cmd is {step_or_load, all selects active, write strobe high}
  pss_top #(.ADDR_W(6)) DUT (
    .i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(1'b1),
    .i_clock_qualify_n(qn), .i_chip_select_1_n(~cmd[1]),
    .i_chip_select_2(cmd[1]), .i_chip_select_3_n(~cmd[1]),
    .i_burst_step_or_load(cmd[2]), .i_write_strobe_n(cmd[0]),
    .i_byte_lane_write_n(ln), .i_addr(ad), .i_burst_order(order),
    .i_output_drive_n(drn), .i_sleep_request(slp), .i_data_io(dq_in),
    .o_data_io(dq_out), .o_data_io_oe(oe), .i_lane_parity_io(pq_in),
    .o_lane_parity_io(pq_out), .o_lane_parity_io_oe(poe),
    .o_sleeping(sleeping));
  pss_ctl_model u_ctl (.i_clk_sys(clk_sys), .i_put(put), .i_word(pw),
    .i_dev_oe(oe), .o_data(dq_in), .o_parity(pq_in), .o_clash(clash));
  // ************************
  // helpers
  // ************************
  function automatic logic [35:0] pat(input logic [5:0] a);
    return {a[3:0], {4{2'h2, a}}} ^ 36'h5_a5a5_a5a5;
  endfunction
  function automatic logic [35:0] merge(input logic [35:0] o,
    input logic [35:0] w, input logic [3:0] n);
    merge = o;
    for (int k = 0; k < 4; k++) begin
      if (!n[k]) begin
        merge[8*k +: 8] = w[8*k +: 8];
        merge[32+k] = w[32+k];
      end
    end
  endfunction
  function automatic logic [5:0] ba(input logic [5:0] s, input int k);
    logic [1:0] b;
    b = k[1:0];
    return {s[5:2], order ? s[1:0] ^ b : s[1:0] + b};
  endfunction
  task chk_word(input string n, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task print_verdict;
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task cyc(input logic [2:0] c, input logic [3:0] n, input logic [5:0] a,
    input logic p, input logic [35:0] d);
    cmd = c;
    ln = n;
    ad = a;
    put = p;
    pw = d;
    @(negedge clk_sys);
  endtask
  task idle;
    cyc(3'h1, 4'hf, 6'h00, 1'b0, 36'h0_0000_0000);
  endtask
  task do_reset;
    @(negedge clk_sys);
    reset = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
  endtask
  // ************************
  // scenarios
  // ************************
  task wr1(input logic [5:0] a, input logic [3:0] n, input logic [35:0] w);
    cyc(3'h2, n, a, 1'b0, 36'h0_0000_0000);
    idle();
    chk_bit("oe after write", 1'b0, oe);
    cyc(3'h1, 4'hf, 6'h00, 1'b1, w);
    ex[a] = merge(ex[a], w, n);
  endtask
  task rd1(input logic [5:0] a);
    cyc(3'h3, 4'hf, a, 1'b0, 36'h0_0000_0000);
    idle();
    chk_word("read data", ex[a], rdw);
    chk_bit("parity drive", 1'b1, poe);
    drn = 1'b1;
    #1 chk_bit("drive released", 1'b0, oe);
    @(negedge clk_sys);
    drn = 1'b0;
    #1 chk_bit("deselect float", 1'b0, oe);
    @(negedge clk_sys);
  endtask
  task t_b2b;
    cyc(3'h3, 4'hf, 6'h05, 1'b0, 36'h0_0000_0000);
    cyc(3'h2, 4'h0, 6'h06, 1'b0, 36'h0_0000_0000);
    chk_word("read then write", ex[5], rdw);
    cyc(3'h3, 4'hf, 6'h05, 1'b0, 36'h0_0000_0000);
    chk_bit("write turnaround", 1'b0, oe);
    cyc(3'h1, 4'hf, 6'h00, 1'b1, pat(6'h06));
    ex[6] = pat(6'h06);
    chk_word("write then read", ex[5], rdw);
    rd1(6'h06);
  endtask
  // continue beats flip the strobe, drop selects and move the address
  task automatic burst(input logic w, input logic [5:0] s, input int nb,
    input int st);
    logic [2:0] c;
    for (int k = 0; k < nb + 2; k++) begin
      if (k == st) begin
        qn = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk_word("stall hold", ex[ba(s, k - 2)], rdw);
        qn = 1'b0;
      end
      c = (k == 0) ? {2'h1, ~w} : (k < nb) ? {2'h2, w} : 3'h1;
      if (w && k >= 2) ex[ba(s, k - 2)] = pat(ba(s, k - 2) ^ 6'h3f);
      cyc(c, 4'h0, k == 0 ? s : ~s, w && k >= 2, ex[ba(s, k - 2)]);
      if (!w && k >= 1 && k <= nb)
        chk_word("burst beat", ex[ba(s, k - 1)], rdw);
    end
  endtask
  task t_sleep;
    slp = 1'b1;
    idle();
    chk_bit("sleep one edge", 1'b0, sleeping);
    idle();
    chk_bit("sleep two edges", 1'b1, sleeping);
    slp = 1'b0;
    idle();
    chk_bit("wake one edge", 1'b1, sleeping);
    idle();
    chk_bit("wake two edges", 1'b0, sleeping);
    idle();
    rd1(6'h05);
  endtask
  // watchdog: the sequence needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  initial begin
    do_reset();
    chk_bit("oe at power-up", 1'b0, oe);
    wr1(6'h05, 4'h0, pat(6'h05));
    rd1(6'h05);
    wr1(6'h05, 4'ha, pat(6'h28));
    wr1(6'h05, 4'hf, pat(6'h29));
    rd1(6'h05);
    t_b2b();
    burst(1'b1, 6'h0d, 4, 99);
    burst(1'b0, 6'h0e, 5, 2);
    t_sleep();
    order = 1'b1;
    do_reset();
    burst(1'b1, 6'h16, 4, 99);
    burst(1'b0, 6'h17, 4, 99);
    chk_bit("bus clash", 1'b0, clash);
    print_verdict();
  end
endmodule // tb_top
